// >>> shared/fwp_pkg.sv
// Behaviour
// R1 - A 32-bit source-data address register holds where row-programming data is fetched from.
// R2 - Program protect unlock bit 31 at 1 leaves the program protect register modifiable, 0 locks it.
// R3 - Both unlock bits (31 and 15) can only be cleared by software, and only reset sets them.
// R4 - Program memory below the address 0x1D prefixed to the 24-bit boundary is write-protected.
// R5 - A boundary of zero disables program-flash protection entirely.
// R6 - Protection works on whole pages: the page holding the boundary and all below are protected; the code spares the page at a page-aligned boundary.
// R7 - Protect registers accept a write only after the key unlock sequence has been completed.
// R8 - The boundary field changes only while the program protect unlock bit is 1.
// R9 - Boot protect unlock bit 15 at 1 leaves the boot page protect bits modifiable, 0 locks them.
// R10 - Writes to the boot page protect bits are ignored unless boot unlock is 1 at that write.
// R11 - Boot page 2 protect bit 10 guards 0x1FC01000 to 0x1FC017FF.
// R12 - Boot page 1 protect bit 9 guards 0x1FC00800 to 0x1FC00FFF.
// R13 - Boot page 0 protect bit 8 guards 0x1FC00000 to 0x1FC007FF.
// R14 - Unimplemented bits of both protect registers read as zero.
// R15 - The unlock key register is write-only and reads as zero.
// R16 - A program or erase aimed at a protected page is suppressed and leaves memory unchanged.
package fwp_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_ROW_SOURCE_ADDRESS    = 8'h00;
    localparam logic [7:0] OFS_PROGRAM_FLASH_PROTECT = 8'h04;
    localparam logic [7:0] OFS_BOOT_FLASH_PROTECT    = 8'h08;
    localparam logic [7:0] OFS_UNLOCK_KEY            = 8'h0c;
    localparam logic [7:0] OFS_PROTECT_STATUS        = 8'h10;

    // Field positions
    localparam int PROG_UNLOCK_BIT   = 31;
    localparam int BOUNDARY_MSB      = 23;
    localparam int BOOT_UNLOCK_BIT   = 15;
    localparam int BOOT_PAGE_LSB     = 8;
    localparam int BOOT_PAGE_MSB     = 10;
    localparam int STAT_KEY_OPEN_BIT = 0;
    localparam int STAT_DENIED_BIT   = 1;

    // Values after reset
    localparam logic [31:0] RST_ROW_SOURCE_ADDRESS = 32'h0000_0000;
    localparam logic        RST_PROG_UNLOCK        = 1'b1;
    localparam logic [23:0] RST_BOUNDARY           = 24'h00_0000;
    localparam logic        RST_BOOT_UNLOCK        = 1'b1;
    localparam logic [2:0]  RST_BOOT_PAGES         = 3'h7;

    // Memory map of the protected regions
    localparam logic [7:0]  PROG_FLASH_PREFIX = 8'h1d;
    localparam int          PAGE_LSB          = 11;
    localparam logic [31:0] BOOT_ALIAS_BASE   = 32'h1fc0_0000;
    localparam logic [31:0] BOOT_ALIAS_LAST   = 32'h1fc0_17ff;

    // Key words, arbitrary values
    localparam logic [31:0] UNLOCK_KEY_FIRST  = 32'h1234_5678;
    localparam logic [31:0] UNLOCK_KEY_SECOND = 32'h8765_4321;

    typedef enum logic [1:0] {
        FWP_KEY_IDLE,
        FWP_KEY_FIRST_SEEN,
        FWP_KEY_OPEN
    } fwp_key_state_t;

endpackage

// >>> hdl/fwp_page_check.sv
`timescale 1ns/1ps
// Decides whether a flash target address lies in a protected page.
module fwp_page_check (
    // Protection settings
    input  wire logic [23:0] boundary,
    input  wire logic [2:0]  boot_pages,
    // Target
    input  wire logic [31:0] target,
    // Verdict
    output logic             is_protected
);

    logic [20:0] bound_page;
    logic [20:0] ceil_page;
    logic        prog_hit;
    logic        boot_hit;
    logic [1:0]  boot_index;

    always_comb begin
        bound_page = {fwp_pkg::PROG_FLASH_PREFIX, boundary[23:fwp_pkg::PAGE_LSB]};
        // A boundary inside a page protects that whole page too
        ceil_page  = bound_page + {20'h0_0000, |boundary[fwp_pkg::PAGE_LSB-1:0]}; // [R6]
        prog_hit   = (boundary != 24'h00_0000) // [R5]
                     && (target[31:24] == fwp_pkg::PROG_FLASH_PREFIX)
                     && (target[31:fwp_pkg::PAGE_LSB] < ceil_page); // [R4]
        boot_index = target[12:11];
        boot_hit   = 1'b0;
        if (target >= fwp_pkg::BOOT_ALIAS_BASE && target <= fwp_pkg::BOOT_ALIAS_LAST) begin
            case (boot_index)
                2'h0:    boot_hit = boot_pages[0]; // [R13]
                2'h1:    boot_hit = boot_pages[1]; // [R12]
                2'h2:    boot_hit = boot_pages[2]; // [R11]
                default: boot_hit = 1'b0;
            endcase
        end
        is_protected = prog_hit | boot_hit;
    end

endmodule // fwp_page_check

// >>> hdl/fwp_regs.sv
`timescale 1ns/1ps
// Flash write-protect register block with key unlock and operation gate.
module fwp_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Flash operation request from the controller
    input  wire logic        op_req,
    input  wire logic [31:0] op_addr,
    input  wire logic        op_row,
    // Operation verdict towards the sequencer
    output logic             op_go,
    output logic             op_denied,
    output logic      [31:0] op_target,
    output logic      [31:0] op_source,
    // Protection state
    output logic      [31:0] source_data_address,
    output logic             key_open
);

    typedef struct packed {
        logic [31:0]                   rdata;
        logic [31:0]                   src_addr;
        logic                          prog_unlock;
        logic [23:0]                   boundary;
        logic                          boot_unlock;
        logic [2:0]                    boot_pages;
        fwp_pkg::fwp_key_state_t       key_state;
        logic                          open;
        logic                          go;
        logic                          denied;
        logic                          last_denied;
        logic [31:0]                   target;
        logic [31:0]                   source;
    } fwp_state_t;

    fwp_state_t s_q;
    fwp_state_t s_d;

    logic target_protected;

    // Read value of the program protect register
    function automatic logic [31:0] fwp_prog_word(input logic unlock, input logic [23:0] bound);
        logic [31:0] w;
        w = 32'h0000_0000; // [R14]
        w[fwp_pkg::PROG_UNLOCK_BIT] = unlock;
        w[fwp_pkg::BOUNDARY_MSB:0] = bound;
        return w;
    endfunction

    // Read value of the boot protect register
    function automatic logic [31:0] fwp_boot_word(input logic unlock, input logic [2:0] pages);
        logic [31:0] w;
        w = 32'h0000_0000; // [R14]
        w[fwp_pkg::BOOT_UNLOCK_BIT] = unlock;
        w[fwp_pkg::BOOT_PAGE_MSB:fwp_pkg::BOOT_PAGE_LSB] = pages;
        return w;
    endfunction

    fwp_page_check u_page_check (
        .boundary     (s_q.boundary),
        .boot_pages   (s_q.boot_pages),
        .target       (op_addr),
        .is_protected (target_protected)
    );

    logic        wr_prog;
    logic        wr_boot;
    logic        wr_key;
    logic        protect_write;
    logic [31:0] status_word;

    always_comb begin
        s_d = s_q;

        wr_prog       = reg_wr && (reg_addr == fwp_pkg::OFS_PROGRAM_FLASH_PROTECT);
        wr_boot       = reg_wr && (reg_addr == fwp_pkg::OFS_BOOT_FLASH_PROTECT);
        wr_key        = reg_wr && (reg_addr == fwp_pkg::OFS_UNLOCK_KEY);
        // Protect registers take a write only once the key sequence is complete
        protect_write = (s_q.key_state == fwp_pkg::FWP_KEY_OPEN); // [R7]

        status_word = 32'h0000_0000;
        status_word[fwp_pkg::STAT_KEY_OPEN_BIT] = (s_q.key_state == fwp_pkg::FWP_KEY_OPEN);
        status_word[fwp_pkg::STAT_DENIED_BIT]   = s_q.last_denied;

        // Key sequence: two key words in a row, then one protect write
        case (s_q.key_state)
            fwp_pkg::FWP_KEY_IDLE: begin
                if (wr_key && reg_wdata == fwp_pkg::UNLOCK_KEY_FIRST) begin
                    s_d.key_state = fwp_pkg::FWP_KEY_FIRST_SEEN;
                end
            end
            fwp_pkg::FWP_KEY_FIRST_SEEN: begin
                // Any write other than a key word aborts (the first key restarts), so stray
                // stores cannot complete a half-done sequence later
                if (reg_wr) begin
                    if (wr_key && reg_wdata == fwp_pkg::UNLOCK_KEY_SECOND) begin
                        s_d.key_state = fwp_pkg::FWP_KEY_OPEN; // [R7]
                    end else if (wr_key && reg_wdata == fwp_pkg::UNLOCK_KEY_FIRST) begin
                        s_d.key_state = fwp_pkg::FWP_KEY_FIRST_SEEN;
                    end else begin
                        s_d.key_state = fwp_pkg::FWP_KEY_IDLE;
                    end
                end
            end
            fwp_pkg::FWP_KEY_OPEN: begin
                // The unlock is spent by the next write of any kind
                if (reg_wr) begin
                    s_d.key_state = fwp_pkg::FWP_KEY_IDLE;
                end
            end
            default: begin
                s_d.key_state = fwp_pkg::FWP_KEY_IDLE;
            end
        endcase
        // Registered copy, so the key_open port leaves a flip-flop, not a decoder
        s_d.open = (s_d.key_state == fwp_pkg::FWP_KEY_OPEN); // [R7]

        // Register writes
        if (reg_wr) begin
            if (reg_addr == fwp_pkg::OFS_ROW_SOURCE_ADDRESS) begin
                s_d.src_addr = reg_wdata; // [R1]
            end
            if (wr_prog && protect_write) begin // [R7]
                // Boundary moves only while the old unlock value is still 1
                if (s_q.prog_unlock) begin // [R2] [R8]
                    s_d.boundary = reg_wdata[fwp_pkg::BOUNDARY_MSB:0];
                end
                // Clear only: a written 1 cannot revive a cleared unlock
                s_d.prog_unlock = s_q.prog_unlock & reg_wdata[fwp_pkg::PROG_UNLOCK_BIT]; // [R3]
            end
            if (wr_boot && protect_write) begin // [R7]
                if (s_q.boot_unlock) begin // [R9] [R10]
                    s_d.boot_pages =
                        reg_wdata[fwp_pkg::BOOT_PAGE_MSB:fwp_pkg::BOOT_PAGE_LSB];
                end
                s_d.boot_unlock = s_q.boot_unlock & reg_wdata[fwp_pkg::BOOT_UNLOCK_BIT]; // [R3]
            end
        end

        // Register reads, answered in the following cycle
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                fwp_pkg::OFS_ROW_SOURCE_ADDRESS: begin
                    s_d.rdata = s_q.src_addr;
                end
                fwp_pkg::OFS_PROGRAM_FLASH_PROTECT: begin
                    s_d.rdata = fwp_prog_word(s_q.prog_unlock, s_q.boundary); // [R14]
                end
                fwp_pkg::OFS_BOOT_FLASH_PROTECT: begin
                    s_d.rdata = fwp_boot_word(s_q.boot_unlock, s_q.boot_pages); // [R14]
                end
                fwp_pkg::OFS_UNLOCK_KEY: begin
                    s_d.rdata = 32'h0000_0000; // [R15]
                end
                fwp_pkg::OFS_PROTECT_STATUS: begin
                    s_d.rdata = status_word;
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Operation gate: verdict one cycle after the request
        s_d.go     = 1'b0;
        s_d.denied = 1'b0;
        if (op_req) begin
            s_d.target = op_addr;
            if (target_protected) begin
                s_d.denied      = 1'b1; // [R16]
                s_d.last_denied = 1'b1;
            end else begin
                s_d.go          = 1'b1;
                s_d.last_denied = 1'b0;
                // Row program fetches its data from the source address
                if (op_row) begin
                    s_d.source = s_q.src_addr; // [R1]
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q.rdata       <= 32'h0000_0000;
            s_q.src_addr    <= fwp_pkg::RST_ROW_SOURCE_ADDRESS;
            s_q.prog_unlock <= fwp_pkg::RST_PROG_UNLOCK; // [R3]
            s_q.boundary    <= fwp_pkg::RST_BOUNDARY;
            s_q.boot_unlock <= fwp_pkg::RST_BOOT_UNLOCK; // [R3]
            s_q.boot_pages  <= fwp_pkg::RST_BOOT_PAGES;
            s_q.key_state   <= fwp_pkg::FWP_KEY_IDLE;
            s_q.open        <= 1'b0;
            s_q.go          <= 1'b0;
            s_q.denied      <= 1'b0;
            s_q.last_denied <= 1'b0;
            s_q.target      <= 32'h0000_0000;
            s_q.source      <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata           = s_q.rdata;
    assign op_go               = s_q.go;
    assign op_denied           = s_q.denied;
    assign op_target           = s_q.target;
    assign op_source           = s_q.source;
    assign source_data_address = s_q.src_addr;
    assign key_open            = s_q.open;

endmodule // fwp_regs

// >>> testbench/fwp_regs_monitor.sv
`timescale 1ns/1ps
// Watches the register port and the operation gate
module fwp_regs_monitor (
    // Clock and reset
    input logic        clk,
    input logic        rst,
    // Register port
    input logic [7:0]  reg_addr,
    input logic [31:0] reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [31:0] reg_rdata,
    // Operation gate
    input logic        op_req,
    input logic [31:0] op_addr,
    input logic        op_row,
    input logic        op_go,
    input logic        op_denied,
    input logic [31:0] op_target,
    input logic [31:0] op_source,
    // State
    input logic [31:0] source_data_address,
    input logic        key_open
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_key_read_zero: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == 32'h0)
        else $error("key register read not zero");
    a_prog_rsvd_zero: assert property (
        reg_rd && reg_addr == 8'h04 |=> reg_rdata[30:24] == 7'h0)
        else $error("program protect reserved bits set");
    a_boot_rsvd_zero: assert property (
        reg_rd && reg_addr == 8'h08 |=> (reg_rdata & 32'hffff_78ff) == 32'h0)
        else $error("boot protect reserved bits set");
    a_one_verdict: assert property (op_req |=> op_go != op_denied)
        else $error("request without exactly one verdict");
    a_no_spurious: assert property (!op_req |=> !op_go && !op_denied)
        else $error("verdict without request");
    a_target_copy: assert property (op_req |=> op_target == $past(op_addr))
        else $error("target not captured");
    a_src_write: assert property (
        reg_wr && reg_addr == 8'h00 |=> source_data_address == $past(reg_wdata))
        else $error("source address not written");
    a_src_handoff: assert property (
        op_req && op_row |=> (op_go |-> op_source == $past(source_data_address)))
        else $error("row source not handed on");
    a_free_region: assert property (
        op_req && op_addr[31:24] != 8'h1d
        && (op_addr < 32'h1fc0_0000 || op_addr > 32'h1fc0_17ff) |=> op_go)
        else $error("unprotected target denied");
    a_key_consumed: assert property (key_open && reg_wr |=> !key_open)
        else $error("unlock not consumed by a write");
endmodule // fwp_regs_monitor

bind fwp_regs fwp_regs_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_req(op_req), .op_addr(op_addr), .op_row(op_row), .op_go(op_go),
    .op_denied(op_denied), .op_target(op_target), .op_source(op_source),
    .source_data_address(source_data_address), .key_open(key_open));

// >>> testbench/fwp_regs_tb.sv
`timescale 1ns/1ps
module fwp_regs_tb;
    logic        clk, rst, reg_wr, reg_rd, op_req, op_row, op_go, op_denied, key_open;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, op_addr, op_target, op_source, src_q, r, es;
    logic [23:0] eb;
    logic [2:0]  ep;
    int          n_errors, compares;

    fwp_regs dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_req(op_req),
        .op_addr(op_addr), .op_row(op_row), .op_go(op_go), .op_denied(op_denied),
        .op_target(op_target), .op_source(op_source), .source_data_address(src_q),
        .key_open(key_open));

    always #20 clk = ~clk;

    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Whole 2 KB pages: a boundary inside a page protects that page too
    function logic exp_prot(input logic [31:0] a, input logic [23:0] b, input logic [2:0] p);
        logic [31:0] lim;
        logic [20:0] pg;
        lim = {8'h1d, b};
        pg = lim[31:11] + {20'h0, |lim[10:0]};
        if (a >= 32'h1fc0_0000 && a <= 32'h1fc0_17ff) return p[a[12:11]];
        return a[31:24] == 8'h1d && b != 24'h0 && a[31:11] < pg;
    endfunction

    function logic [31:0] pick(input logic [31:0] v, input logic [23:0] b);
        case (v[31:30])
            2'h0: return {8'h1d, 10'h0, v[13:0]};
            2'h1: return {8'h1d, b} - {31'h0, v[0]};
            2'h2: return {19'h0fe00, v[12:11] == 2'h3 ? 2'h2 : v[12:11], v[10:0]};
            default: return v;
        endcase
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge clk);
    endtask

    task unlock;
        wr(8'h0c, fwp_pkg::UNLOCK_KEY_FIRST);
        wr(8'h0c, fwp_pkg::UNLOCK_KEY_SECOND);
        chk({31'h0, key_open}, 32'h0000_0001);
    endtask

    task op(input logic [31:0] a, input logic row);
        logic e;
        e = exp_prot(a, eb, ep);
        op_addr <= a;
        op_row <= row;
        op_req <= 1'b1;
        @(posedge clk);
        op_req <= 1'b0;
        #1 chk({31'h0, op_go}, {31'h0, !e});
        chk({31'h0, op_denied}, {31'h0, e});
        chk(op_target, a);
        if (row && !e) chk(op_source, es);
        @(posedge clk);
    endtask

    task give_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Cut a hang well past the expected 1400 or so cycles
    initial begin
        #1_000_000;
        n_errors++;
        give_verdict();
    end

    initial begin
        {clk, reg_wr, reg_rd, op_req, op_row, reg_addr, reg_wdata, op_addr} = '0;
        rst = 1'b1;
        r = 32'h0001_1a11;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(8'h04, 32'h8000_0000);
        rd(8'h08, 32'h0000_8700);
        rd(8'h00, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h04, 32'h8000_1000);
        wr(8'h08, 32'h0);
        rd(8'h04, 32'h8000_0000);
        rd(8'h08, 32'h0000_8700);
        for (int i = 0; i < 40; i++) begin
            r = lfsr(r);
            es = r;
            wr(8'h00, es);
            chk(src_q, es);
            rd(8'h00, es);
            r = lfsr(r);
            eb = i == 0 ? 24'h0 : i == 1 ? 24'h000800 : {10'h0, r[13:0]};
            unlock();
            wr(8'h04, {8'hff, eb});
            rd(8'h04, {8'h80, eb});
            ep = r[18:16];
            unlock();
            wr(8'h08, {16'hffff, 5'h1f, ep, 8'hff});
            rd(8'h08, {16'h0, 5'h10, ep, 8'h0});
            rd(8'h0c, 32'h0);
            for (int j = 0; j < 6; j++) begin
                r = lfsr(r);
                op(pick(r, eb), r[29]);
            end
        end
        // Clearing the unlock in the same write still applies the new fields
        eb = 24'h001800;
        unlock();
        wr(8'h04, {8'h00, eb});
        rd(8'h04, {8'h00, eb});
        unlock();
        wr(8'h04, 32'h8000_0400);
        rd(8'h04, {8'h00, eb});
        ep = 3'h1;
        unlock();
        wr(8'h08, 32'h0000_0100);
        rd(8'h08, 32'h0000_0100);
        unlock();
        wr(8'h08, 32'h0000_8700);
        rd(8'h08, 32'h0000_0100);
        op(32'h1fc0_0000, 1'b0);
        rd(8'h10, 32'h0000_0002);
        op(32'h1fc0_0800, 1'b1);
        op(32'h1fc0_17ff, 1'b0);
        op(32'h1d00_17ff, 1'b0);
        op(32'h1d00_1800, 1'b1);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(8'h04, 32'h8000_0000);
        rd(8'h08, 32'h0000_8700);
        give_verdict();
    end
endmodule // fwp_regs_tb
